//--- hdl/fcc_defs.svh
// Register offsets, field positions, reset values and timing figures of the channel block.
`ifndef FCC_DEFS_SVH
`define FCC_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define FCC_OFS_CONFIG 8'h00
`define FCC_OFS_FILTER 8'h04
`define FCC_OFS_TIMEOUT 8'h08
`define FCC_OFS_RANGE 8'h0C
`define FCC_OFS_DECODE 8'h10
`define FCC_OFS_INVERT 8'h14
`define FCC_OFS_REFRESH 8'h18
`define FCC_OFS_SCAN 8'h1C
`define FCC_OFS_CMD 8'h20
`define FCC_OFS_LOAD 8'h24
`define FCC_OFS_STATUS 8'h28
`define FCC_BANK_FREQ 3'h2
`define FCC_BANK_COUNT 3'h3

// ==========================================================================
// Field positions
`define FCC_CMD_CH_LSB 0
`define FCC_CMD_OP_LSB 4
`define FCC_STAT_RANGE_LSB 8
`define FCC_STAT_DEAD_LSB 16

// ==========================================================================
// Field codes and reset values
`define FCC_FILTER_RST 8'h00
`define FCC_FILTER_MAX 8'hC8
`define FCC_TIMEOUT_MIN 11'h014
`define FCC_TIMEOUT_MAX 11'h708
`define FCC_TIMEOUT_RST 11'h708
`define FCC_REFRESH_MIN 10'h014
`define FCC_REFRESH_MAX 10'h3E8
`define FCC_REFRESH_RST 10'h000
`define FCC_RANGE_LOW 2'h0
`define FCC_RANGE_HIGH 2'h1
`define FCC_RANGE_AUTO 2'h2
`define FCC_RANGE_RST 2'h2
`define FCC_DEC_PDIR 3'h0
`define FCC_DEC_UPDN 3'h1
`define FCC_DEC_QUAD 3'h4
`define FCC_OP_START 2'h1
`define FCC_OP_STOP 2'h2
`define FCC_OP_LOAD 2'h3

// ==========================================================================
// Timing figures
`define FCC_CLK_NS 10
`define FCC_US_NS 1000
`define FCC_MS_NS 1000000
`define FCC_NS_PER_S 1000000000
`define FCC_AUTO_UP_HZ 32'h00000DAC
`define FCC_AUTO_DOWN_HZ 32'h000003E8
`define FCC_GATE_MS 10'h064
`define FCC_GATE_SCALE 32'h0000000A

`endif

//--- hdl/fcc_glitch_filter.sv
// Glitch filter that passes a new level only after it has stood for the reject width.
`timescale 1ns/1ps
`include "fcc_defs.svh"
module fcc_glitch_filter #(
	parameter int WIDTH_BITS = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic raw_level,
	input wire logic us_tick,
	input wire logic [WIDTH_BITS-1:0] reject_width,
	output logic clean_level
);
	logic [WIDTH_BITS-1:0] stable_us;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stable_us <= '0;
			clean_level <= 1'b0;
		end else if (raw_level == clean_level) begin
			stable_us <= '0;
		end else if (reject_width == '0) begin
			clean_level <= raw_level;
		end else if (us_tick) begin
			if (WIDTH_BITS'(stable_us + 1'b1) >= reject_width) begin
				clean_level <= raw_level;
				stable_us <= '0;
			end else begin
				stable_us <= WIDTH_BITS'(stable_us + 1'b1);
			end
		end
	end
endmodule

//--- hdl/fcc_pkg.sv
// Types shared by the channel block.
package fcc_pkg;
	typedef enum logic [1:0] {fcc_mode_freq, fcc_mode_updn4, fcc_mode_up8} fcc_mode_type;
	typedef enum logic {fcc_div_load, fcc_div_run} fcc_div_type;
endpackage

//--- hdl/fcc_top.sv
// Eight-input frequency meter and counter bank with an APB register file.
`timescale 1ns/1ps
`include "fcc_defs.svh"
// ==========================================================================
module fcc_top #(
	parameter int CHANNELS = 8,
	parameter int US_CYCLES = `FCC_US_NS / `FCC_CLK_NS,
	parameter int MS_CYCLES = `FCC_MS_NS / `FCC_CLK_NS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [CHANNELS-1:0] pulse_in,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import fcc_pkg::*;

	// Cycles per second follow the millisecond base, so both range methods agree when it is shortened.
	localparam logic [31:0] CLK_HZ = 32'(MS_CYCLES * 1000);
	localparam int PAIRS = CHANNELS / 2;

	logic [1:0] cfg_mode;
	logic [7:0] glitch_reject_width;
	logic [10:0] no_edge_window;
	logic [1:0] range_select;
	logic [3*PAIRS-1:0] input_decode_select;
	logic [CHANNELS-1:0] invert_mask;
	logic [9:0] refresh_interval;
	logic [31:0] load_value;
	logic [CHANNELS-1:0] running;
	logic [31:0] count [CHANNELS];
	logic [31:0] freq_result [CHANNELS];
	logic [31:0] period_cnt [CHANNELS];
	logic [31:0] period_latch [CHANNELS];
	logic [31:0] low_freq [CHANNELS];
	logic [31:0] edge_cnt [CHANNELS];
	logic [31:0] high_freq [CHANNELS];
	logic [31:0] chosen [CHANNELS];
	logic [10:0] idle_ms [CHANNELS];
	logic [CHANNELS-1:0] dead, seen, auto_high, use_high;
	logic [CHANNELS-1:0] sync_a, sync_b, shaped, filt, filt_prev, rise, change;
	logic [CHANNELS-1:0] step_up, step_dn;
	logic [31:0] us_div, ms_div;
	logic us_tick, ms_tick;
	logic [9:0] gate_ms, refresh_ms;
	logic [31:0] rd_word;
	logic rd_ok;
	fcc_mode_type mode;

	// ==========================================================================
	// Field interpretation
	function automatic fcc_mode_type mode_of(input logic [1:0] code);
		mode_of = (code == 2'h1) ? fcc_mode_updn4 : (code == 2'h2) ? fcc_mode_up8 : fcc_mode_freq;
	endfunction

	function automatic logic [10:0] timeout_of(input logic [10:0] ms);
		if (ms < `FCC_TIMEOUT_MIN || ms > `FCC_TIMEOUT_MAX) begin
			timeout_of = `FCC_TIMEOUT_MAX;
		end else begin
			timeout_of = ms;
		end
	endfunction

	function automatic logic [9:0] refresh_of(input logic [9:0] ms);
		if (ms == 10'h000) begin
			refresh_of = ms;
		end else if (ms < `FCC_REFRESH_MIN) begin
			refresh_of = `FCC_REFRESH_MIN;
		end else if (ms > `FCC_REFRESH_MAX) begin
			refresh_of = `FCC_REFRESH_MAX;
		end else begin
			refresh_of = ms;
		end
	endfunction

	function automatic logic [2:0] decode_of(input logic [2:0] code);
		decode_of = (code == `FCC_DEC_UPDN || code == `FCC_DEC_QUAD) ? code : `FCC_DEC_PDIR;
	endfunction

	assign mode = mode_of(cfg_mode);

	// ==========================================================================
	// APB slave
	logic apb_setup, apb_write, cmd_hit, scan_hit;
	logic [2:0] cmd_ch;
	logic [1:0] cmd_op;
	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pwrite;
	assign cmd_hit = apb_write && paddr == `FCC_OFS_CMD;
	assign scan_hit = apb_write && paddr == `FCC_OFS_SCAN;
	assign cmd_ch = pwdata[`FCC_CMD_CH_LSB +: 3];
	assign cmd_op = pwdata[`FCC_CMD_OP_LSB +: 2];
	assign pready = 1'b1;

	always_comb begin
		rd_word = 32'h0;
		rd_ok = (paddr[1:0] == 2'h0);
		if (paddr[7:5] == `FCC_BANK_FREQ) begin
			rd_word = freq_result[paddr[4:2]];
		end else if (paddr[7:5] == `FCC_BANK_COUNT) begin
			rd_word = count[paddr[4:2]];
		end else begin
			unique case (paddr)
				`FCC_OFS_CONFIG: rd_word = {30'h0, cfg_mode};
				`FCC_OFS_FILTER: rd_word = {24'h0, glitch_reject_width};
				`FCC_OFS_TIMEOUT: rd_word = {21'h0, no_edge_window};
				`FCC_OFS_RANGE: rd_word = {30'h0, range_select};
				`FCC_OFS_DECODE: rd_word = 32'(input_decode_select);
				`FCC_OFS_INVERT: rd_word = 32'(invert_mask);
				`FCC_OFS_REFRESH: rd_word = {22'h0, refresh_interval};
				`FCC_OFS_SCAN, `FCC_OFS_CMD: rd_word = 32'h0;
				`FCC_OFS_LOAD: rd_word = load_value;
				`FCC_OFS_STATUS: begin
					rd_word[`FCC_STAT_RANGE_LSB +: CHANNELS] = use_high;
					rd_word[`FCC_STAT_DEAD_LSB +: CHANNELS] = dead;
					rd_word[CHANNELS-1:0] = running;
				end
				default: rd_ok = 1'b0;
			endcase
		end
	end

	assign pslverr = psel & penable & ~rd_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (apb_setup) begin
			prdata <= rd_word;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_mode <= 2'h0;
			glitch_reject_width <= `FCC_FILTER_RST;
			no_edge_window <= `FCC_TIMEOUT_RST;
			range_select <= `FCC_RANGE_RST;
			input_decode_select <= '0;
			invert_mask <= '0;
			refresh_interval <= `FCC_REFRESH_RST;
			load_value <= 32'h0;
		end else if (apb_write) begin
			unique case (paddr)
				`FCC_OFS_CONFIG: cfg_mode <= pwdata[1:0];
				`FCC_OFS_FILTER: glitch_reject_width <= pwdata[7:0];
				`FCC_OFS_TIMEOUT: no_edge_window <= pwdata[10:0];
				`FCC_OFS_RANGE: range_select <= pwdata[1:0];
				`FCC_OFS_DECODE: input_decode_select <= pwdata[3*PAIRS-1:0];
				`FCC_OFS_INVERT: invert_mask <= pwdata[CHANNELS-1:0];
				`FCC_OFS_REFRESH: refresh_interval <= pwdata[9:0];
				`FCC_OFS_LOAD: load_value <= pwdata;
				default: ;
			endcase
		end
	end

	// ==========================================================================
	// Time bases
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			us_div <= 32'h0;
			us_tick <= 1'b0;
		end else begin
			us_tick <= (us_div == 32'(US_CYCLES - 1));
			us_div <= (us_div == 32'(US_CYCLES - 1)) ? 32'h0 : us_div + 32'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_div <= 32'h0;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= (ms_div == 32'(MS_CYCLES - 1));
			ms_div <= (ms_div == 32'(MS_CYCLES - 1)) ? 32'h0 : ms_div + 32'h1;
		end
	end

	// ==========================================================================
	// Input conditioning
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= '0;
			sync_b <= '0;
			filt_prev <= '0;
		end else begin
			sync_a <= pulse_in;
			sync_b <= sync_a;
			filt_prev <= filt;
		end
	end

	assign shaped = sync_b ^ invert_mask;

	for (genvar gi = 0; gi < CHANNELS; gi++) begin : g_filt
		fcc_glitch_filter #(.WIDTH_BITS(8)) u_filt (
			.pclk(pclk),
			.presetn(presetn),
			.raw_level(shaped[gi]),
			.us_tick(us_tick),
			.reject_width((glitch_reject_width > `FCC_FILTER_MAX) ? `FCC_FILTER_MAX
				: glitch_reject_width),
			.clean_level(filt[gi])
		);
	end

	assign rise = filt & ~filt_prev;
	assign change = filt ^ filt_prev;

	// ==========================================================================
	// Counter bank
	always_comb begin
		logic [2:0] dec;
		dec = 3'h0;
		step_up = '0;
		step_dn = '0;
		if (mode == fcc_mode_up8) begin
			step_up = rise;
		end else if (mode == fcc_mode_updn4) begin
			for (int k = 0; k < PAIRS; k++) begin
				dec = decode_of(input_decode_select[3*k +: 3]);
				if (dec == `FCC_DEC_UPDN) begin
					step_up[k] = rise[2*k];
					step_dn[k] = rise[2*k+1];
				end else if (dec == `FCC_DEC_QUAD) begin
					if (change[2*k] ^ change[2*k+1]) begin
						step_up[k] = filt[2*k] ^ filt_prev[2*k+1];
						step_dn[k] = ~(filt[2*k] ^ filt_prev[2*k+1]);
					end
				end else begin
					step_up[k] = rise[2*k] & filt[2*k+1];
					step_dn[k] = rise[2*k] & ~filt[2*k+1];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			running <= '0;
		end else if (cmd_hit && cmd_op == `FCC_OP_START) begin
			running[cmd_ch] <= 1'b1;
		end else if (cmd_hit && cmd_op == `FCC_OP_STOP) begin
			running[cmd_ch] <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < CHANNELS; k++) count[k] <= 32'h0;
		end else begin
			for (int k = 0; k < CHANNELS; k++) begin
				if (cmd_hit && cmd_op == `FCC_OP_LOAD && cmd_ch == 3'(k)) begin
					count[k] <= load_value;
				end else if (running[k] && (step_up[k] ^ step_dn[k])) begin
					count[k] <= step_up[k] ? count[k] + 32'h1 : count[k] - 32'h1;
				end
			end
		end
	end

	// ==========================================================================
	// Frequency measurement
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dead <= '0;
			for (int k = 0; k < CHANNELS; k++) idle_ms[k] <= 11'h000;
		end else begin
			for (int k = 0; k < CHANNELS; k++) begin
				if (rise[k]) begin
					idle_ms[k] <= 11'h000;
					dead[k] <= 1'b0;
				end else if (ms_tick && !dead[k]) begin
					if (11'(idle_ms[k] + 11'h001) >= timeout_of(no_edge_window)) begin
						dead[k] <= 1'b1;
					end else begin
						idle_ms[k] <= 11'(idle_ms[k] + 11'h001);
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen <= '0;
			for (int k = 0; k < CHANNELS; k++) begin
				period_cnt[k] <= 32'h0;
				period_latch[k] <= 32'h0;
			end
		end else begin
			for (int k = 0; k < CHANNELS; k++) begin
				if (rise[k]) begin
					period_latch[k] <= (dead[k] || !seen[k]) ? 32'h0 : period_cnt[k] + 32'h1;
					period_cnt[k] <= 32'h0;
					seen[k] <= 1'b1;
				end else begin
					if (dead[k]) seen[k] <= 1'b0;
					if (period_cnt[k] != 32'hFFFFFFFF) period_cnt[k] <= period_cnt[k] + 32'h1;
				end
			end
		end
	end

	// Low range: a shared serial divider turns each latched period into hertz.
	fcc_div_type div_state;
	logic [2:0] div_ch;
	logic [4:0] div_bit;
	logic [31:0] div_num, div_den, div_quot;
	logic [32:0] div_rem, div_trial;
	logic div_ge;
	assign div_trial = {div_rem[31:0], div_num[31]};
	assign div_ge = (div_trial >= {1'b0, div_den});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_state <= fcc_div_load;
			div_ch <= 3'h0;
			div_bit <= 5'h00;
			div_num <= 32'h0;
			div_den <= 32'h0;
			div_quot <= 32'h0;
			div_rem <= 33'h0;
			for (int k = 0; k < CHANNELS; k++) low_freq[k] <= 32'h0;
		end else begin
			unique case (div_state)
				fcc_div_load: begin
					div_den <= period_latch[div_ch];
					div_num <= CLK_HZ;
					div_rem <= 33'h0;
					div_quot <= 32'h0;
					div_bit <= 5'h00;
					div_state <= fcc_div_run;
				end
				fcc_div_run: begin
					div_rem <= div_ge ? 33'(div_trial - {1'b0, div_den}) : div_trial;
					div_quot <= {div_quot[30:0], div_ge};
					div_num <= {div_num[30:0], 1'b0};
					div_bit <= 5'(div_bit + 5'h01);
					if (div_bit == 5'h1F) begin
						low_freq[div_ch] <= (div_den == 32'h0) ? 32'h0 : {div_quot[30:0], div_ge};
						div_ch <= 3'(div_ch + 3'h1);
						div_state <= fcc_div_load;
					end
				end
			endcase
		end
	end

	// High range: edges counted over a fixed gate and scaled to hertz.
	logic gate_end;
	assign gate_end = ms_tick && gate_ms == 10'(`FCC_GATE_MS - 10'h001);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_ms <= 10'h000;
			for (int k = 0; k < CHANNELS; k++) begin
				edge_cnt[k] <= 32'h0;
				high_freq[k] <= 32'h0;
			end
		end else begin
			if (ms_tick) gate_ms <= gate_end ? 10'h000 : 10'(gate_ms + 10'h001);
			for (int k = 0; k < CHANNELS; k++) begin
				if (gate_end) begin
					high_freq[k] <= edge_cnt[k] * `FCC_GATE_SCALE;
					edge_cnt[k] <= {31'h0, rise[k]};
				end else if (rise[k]) begin
					edge_cnt[k] <= edge_cnt[k] + 32'h1;
				end
			end
		end
	end

	always_comb begin
		for (int k = 0; k < CHANNELS; k++) begin
			unique case (range_select)
				`FCC_RANGE_LOW: use_high[k] = 1'b0;
				`FCC_RANGE_HIGH: use_high[k] = 1'b1;
				default: use_high[k] = auto_high[k];
			endcase
			chosen[k] = dead[k] ? 32'h0 : (use_high[k] ? high_freq[k] : low_freq[k]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auto_high <= '0;
		end else begin
			for (int k = 0; k < CHANNELS; k++) begin
				if (chosen[k] > `FCC_AUTO_UP_HZ) begin
					auto_high[k] <= 1'b1;
				end else if (chosen[k] < `FCC_AUTO_DOWN_HZ) begin
					auto_high[k] <= 1'b0;
				end
			end
		end
	end

	// Results move to the readable bank only on a scan strobe once the interval is due.
	logic publish;
	assign publish = scan_hit && mode == fcc_mode_freq
		&& (refresh_of(refresh_interval) == 10'h000 || refresh_ms >= refresh_of(refresh_interval));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refresh_ms <= 10'h000;
			for (int k = 0; k < CHANNELS; k++) freq_result[k] <= 32'h0;
		end else if (publish) begin
			refresh_ms <= 10'h000;
			for (int k = 0; k < CHANNELS; k++) freq_result[k] <= chosen[k];
		end else if (ms_tick && refresh_ms != `FCC_REFRESH_MAX) begin
			refresh_ms <= 10'(refresh_ms + 10'h001);
		end
	end
endmodule

//--- verif/fcc_pulse_src.sv
// Behavioural pulse, direction and quadrature sources on the input pins.
`timescale 1ns/1ps
module fcc_pulse_src (
	input wire logic pclk,
	output logic [7:0] pins
);
	int half [8];
	int cnt [8];
	initial begin
		pins = 8'h00;
		foreach (half[i]) begin
			half[i] = 0;
			cnt[i] = 0;
		end
	end
	// Square waves run on every pin whose half period is set.
	always @(posedge pclk) begin
		for (int i = 0; i < 8; i++) begin
			if (half[i] != 0) begin
				cnt[i]++;
				if (cnt[i] >= half[i]) begin
					cnt[i] = 0;
					pins[i] <= ~pins[i];
				end
			end
		end
	end
	task automatic pulse(input int ch, input int w, input int n);
		repeat (n) begin
			@(posedge pclk);
			pins[ch] <= ~pins[ch];
			repeat (w) @(posedge pclk);
			pins[ch] <= ~pins[ch];
			repeat (w - 1) @(posedge pclk);
		end
	endtask
	task automatic put(input int ch, input logic v);
		@(posedge pclk);
		pins[ch] <= v;
		repeat (3) @(posedge pclk);
	endtask
endmodule

//--- verif/fcc_top_chk.sv
// Register port checker of the channel block.
`timescale 1ns/1ps
module fcc_top_chk #(
	parameter int CHANNELS = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [CHANNELS-1:0] pulse_in,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// ========
	// Access decode
	logic acc;
	logic mapped;
	assign acc = psel && penable;
	assign mapped = paddr[1:0] == 2'h0 && (paddr <= 8'h28 || (paddr >= 8'h40 && paddr <= 8'h7C));
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_rd_setup(logic [7:0] a);
		psel && !penable && !pwrite && paddr == a;
	endsequence
	property p_zero_read(logic [7:0] a);
		s_rd_setup(a) ##1 acc |-> prdata == 32'h0;
	endproperty
	// ========
	// Assertions
	a_ready_high: assert property (pready) else $error("pready low");
	a_err_access: assert property (pslverr |-> acc) else $error("stray error");
	a_err_unmapped:
		assert property (acc && !mapped |-> pslverr) else $error("missing error");
	a_err_mapped:
		assert property (acc && mapped |-> !pslverr) else $error("false error");
	a_bad_read_zero:
		assert property (acc && !mapped && !pwrite |-> prdata == 32'h0) else $error("bad read data");
	a_scan_read_zero: assert property (p_zero_read(8'h1C)) else $error("scan read data");
	a_cmd_read_zero: assert property (p_zero_read(8'h20)) else $error("cmd read data");
	a_reset_clear:
		assert property ($rose(presetn) |-> prdata == 32'h0) else $error("reset data");
	a_read_stands:
		assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
endmodule

//--- verif/fcc_top_tb_top.sv
// Self-checking testbench of the channel block.
`timescale 1ns/1ps
`include "fcc_defs.svh"
module fcc_top_tb_top;
	localparam int CHANNELS = 8;
	localparam int MS_CYCLES = 20;
	logic pclk;
	logic presetn;
	logic [7:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [7:0] pulse_in;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [31:0] rd;
	logic [31:0] v;
	logic err;
	int errors;
	int total_checks;
	int seed;
	int n [8];
	fcc_top #(.CHANNELS(CHANNELS), .US_CYCLES(4), .MS_CYCLES(MS_CYCLES)) uut (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .pulse_in(pulse_in), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	fcc_pulse_src src (.pclk(pclk), .pins(pulse_in));
	initial pclk = 1'b0;
	always #5 pclk = ~pclk;
	// ========
	// Bench tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && t < 50) begin
			t++;
			@(posedge pclk);
		end
		if (t == 50) errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		check(what, rd, exp);
	endtask
	task automatic cmd(input int ch, input logic [1:0] op);
		apb(1'b1, `FCC_OFS_CMD, {26'h0, op, 1'b0, 3'(ch)});
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge pclk);
	endtask
	// A second of the block's time base is a thousand of its shortened milliseconds.
	function automatic logic [31:0] hz(input int period);
		return 32'((MS_CYCLES * 1000) / period);
	endfunction
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#(600000);
		errors++;
		finish_test();
	end
	// ========
	// Main sequence
	initial begin
		seed = 36;
		errors = 0;
		total_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		idle(6);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(`FCC_OFS_CONFIG, 32'h0, "config");
		rchk(`FCC_OFS_FILTER, 32'h0, "filter");
		rchk(`FCC_OFS_TIMEOUT, 32'h708, "timeout");
		rchk(`FCC_OFS_RANGE, 32'h2, "range");
		rchk(`FCC_OFS_STATUS, 32'h0, "status");
		for (int k = 0; k < 16; k++) rchk(8'(8'h40 + 4 * k), 32'h0, "bank");
		rchk(`FCC_OFS_SCAN, 32'h0, "scan");
		apb(1'b0, 8'h30, 32'h0);
		check("unmapped", {31'h0, err}, 32'h1);
		apb(1'b1, 8'h06, 32'hFFFF);
		check("misaligned", {31'h0, err}, 32'h1);
		v = 32'($unsigned($random(seed)) % 201);
		apb(1'b1, `FCC_OFS_FILTER, v);
		rchk(`FCC_OFS_FILTER, v, "filter rw");
		apb(1'b1, `FCC_OFS_FILTER, 32'h0);
		src.put(1, 1'b1);
		apb(1'b1, `FCC_OFS_CONFIG, 32'h2);
		apb(1'b1, `FCC_OFS_INVERT, 32'h02);
		idle(8);
		for (int k = 0; k < 8; k++) if (k != 5) cmd(k, `FCC_OP_START);
		for (int k = 0; k < 8; k++) begin
			n[k] = 1 + int'($unsigned($random(seed)) % 6);
			src.pulse(k, 3, n[k]);
		end
		idle(10);
		for (int k = 0; k < 8; k++) rchk(8'(8'h60 + 4 * k), k == 5 ? 0 : n[k], "up");
		apb(1'b0, `FCC_OFS_STATUS, 32'h0);
		check("running", rd & 32'hFF, 32'hDF);
		cmd(0, `FCC_OP_STOP);
		src.pulse(0, 3, 2);
		idle(10);
		rchk(8'h60, 32'(n[0]), "stopped");
		v = $random(seed);
		apb(1'b1, `FCC_OFS_LOAD, v);
		cmd(3, `FCC_OP_LOAD);
		rchk(8'h6C, v, "loaded");
		rchk(8'h68, 32'(n[2]), "neighbour");
		apb(1'b1, `FCC_OFS_FILTER, 32'h3);
		src.pulse(2, 8, 3);
		src.pulse(2, 24, 2);
		idle(30);
		rchk(8'h68, 32'(n[2] + 2), "filtered");
		apb(1'b1, `FCC_OFS_FILTER, 32'h0);
		src.put(7, 1'b1);
		apb(1'b1, `FCC_OFS_CONFIG, 32'h1);
		apb(1'b1, `FCC_OFS_DECODE, 32'hF08);
		apb(1'b1, `FCC_OFS_INVERT, 32'h80);
		apb(1'b1, `FCC_OFS_LOAD, 32'h0);
		idle(8);
		for (int k = 0; k < 4; k++) begin
			cmd(k, `FCC_OP_LOAD);
			cmd(k, `FCC_OP_START);
		end
		src.pulse(0, 3, n[0]);
		src.pulse(2, 3, n[1]);
		src.pulse(3, 3, n[2]);
		src.put(4, 1'b1);
		src.put(5, 1'b1);
		src.put(4, 1'b0);
		src.put(5, 1'b0);
		src.pulse(6, 3, n[3]);
		idle(10);
		rchk(8'h60, 32'(n[0]), "pdir up");
		rchk(8'h64, 32'(n[1] - n[2]), "updn");
		rchk(8'h68, 32'h4, "quad");
		rchk(8'h6C, 32'(-n[3]), "pdir down");
		apb(1'b1, `FCC_OFS_CONFIG, 32'h0);
		// Forced low range is used at any frequency; this signal lies between the two switch points.
		apb(1'b1, `FCC_OFS_RANGE, 32'h0);
		apb(1'b1, `FCC_OFS_TIMEOUT, 32'h64);
		apb(1'b1, `FCC_OFS_INVERT, 32'h0);
		src.half[0] = 5;
		idle(3000);
		rchk(8'h40, 32'h0, "before scan");
		apb(1'b1, `FCC_OFS_SCAN, 32'h0);
		rchk(8'h40, hz(10), "low range");
		rchk(8'h44, 32'h0, "silent");
		apb(1'b1, `FCC_OFS_REFRESH, 32'h3E8);
		src.half[0] = 2;
		apb(1'b1, `FCC_OFS_RANGE, 32'h3);
		idle(4200);
		apb(1'b0, `FCC_OFS_STATUS, 32'h0);
		check("auto high", {31'h0, rd[8]}, 32'h1);
		apb(1'b1, `FCC_OFS_SCAN, 32'h0);
		rchk(8'h40, hz(10), "held");
		apb(1'b1, `FCC_OFS_REFRESH, 32'h0);
		apb(1'b1, `FCC_OFS_SCAN, 32'h0);
		rchk(8'h40, hz(4), "high range");
		src.half[0] = 0;
		idle(3000);
		apb(1'b1, `FCC_OFS_SCAN, 32'h0);
		rchk(8'h40, 32'h0, "no edge");
		apb(1'b0, `FCC_OFS_STATUS, 32'h0);
		check("dead", {31'h0, rd[16]}, 32'h1);
		check("auto low", {31'h0, rd[8]}, 32'h0);
		finish_test();
	end
endmodule
bind fcc_top fcc_top_chk #(.CHANNELS(CHANNELS)) u_chk (.pclk(pclk), .presetn(presetn),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.pulse_in(pulse_in), .prdata(prdata), .pready(pready), .pslverr(pslverr));
